// *** core/sep_defs.svh ***
// Constants of the scan emulation port: codes, field positions, reset values, stages
//------------------------------------------------------------------------------
// Overview of operation
// - Test data input captured on rising test clock
// - Selected register shifted out on falling edge
// - Mode select sampled each rising edge, advances controller
// - Secondary mode select also sampled on rising edge
// - Test reset high hands device to scan
// - Test reset low: functional mode, test ignored
// - Event pin zero bidirectional, direction set by scan
// - Float pin also bidirectional emulator line, scan-set
// - Test reset low, pin zero high, float pin low floats outputs
//------------------------------------------------------------------------------
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH

// Instruction register
`define SEP_IR_W        4
`define SEP_IR_BYPASS   4'hF
`define SEP_IR_EMUCTL   4'h2
`define SEP_IR_CAPTURE  4'h1

// Emulation control data register layout
`define SEP_EMU_W       5
`define SEP_EMU_E0_DRV  0
`define SEP_EMU_E0_VAL  1
`define SEP_EMU_E1_DRV  2
`define SEP_EMU_E1_VAL  3
`define SEP_EMU_MS2     4
`define SEP_EMU_RESET   5'h00

// Synchroniser depth and width on the system side
`define SEP_SYNC_STAGES 3
`define SEP_SYNC_W      3
`define SEP_SYNC_TRST   0
`define SEP_SYNC_EMULATOR_EVENT_PIN_ZERO   1
`define SEP_SYNC_EMU1   2

`endif

// *** core/sep_pkg.sv ***
// Types of the scan emulation port
//------------------------------------------------------------------------------
// Package
//------------------------------------------------------------------------------
package sep_pkg;

  // Sixteen controller states
  typedef enum logic [3:0] {
    SEP_TLR, SEP_RTI,
    SEP_SEL_DR, SEP_CAP_DR, SEP_SH_DR, SEP_EX1_DR, SEP_PA_DR, SEP_EX2_DR, SEP_UPD_DR,
    SEP_SEL_IR, SEP_CAP_IR, SEP_SH_IR, SEP_EX1_IR, SEP_PA_IR, SEP_EX2_IR, SEP_UPD_IR
  } sep_tap_state_t;

endpackage : sep_pkg

// *** core/sep_port.sv ***
// Scan emulation port: test access controller, emulator pins and float control
`timescale 1ns/1ps
`include "sep_defs.svh"

module sep_port (
  // System clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Test clock, test reset (high hands the device to scan)
  input  wire logic tck_i,
  input  wire logic trst_i,
  // Serial scan pins
  input  wire logic tms_i,
  input  wire logic secondary_mode_select_i,
  input  wire logic tdi_i,
  output logic      tdo_o,
  output logic      tdo_oe_n_o,
  // Emulator event pin zero, three signals
  input  wire logic emulator_event_pin_zero_i,
  output logic      emulator_event_pin_zero_o,
  output logic      emulator_event_pin_zero_oe_n_o,
  // Combined emulator event and output-float pin, three signals
  input  wire logic emulator_event_float_pin_i,
  output logic      emulator_event_float_pin_o,
  output logic      emulator_event_float_pin_oe_n_o,
  // System-side status
  output logic      scan_control_o,
  output logic      outputs_float_o
);
  import sep_pkg::*;

  //----------------------------------------------------------------------------
  // Test clock domain: controller
  //----------------------------------------------------------------------------
  sep_tap_state_t             state_reg;         // Controller state
  sep_tap_state_t             state_next;        // Controller next state
  logic [`SEP_IR_W-1:0]       ir_sr_reg;         // Instruction shift stage
  logic [`SEP_IR_W-1:0]       ir_reg;            // Active instruction
  logic                       bypass_reg;        // One-bit bypass path
  logic [`SEP_EMU_W-1:0]      emu_sr_reg;        // Emulation control shift stage
  logic [`SEP_EMU_W-1:0]      emu_reg;           // Emulation control, updated
  logic                       ms2_reg;           // Sampled secondary mode select
  logic                       tdo_reg;           // Serial output, falling edge
  logic                       tdo_oe_n_reg;      // Serial output enable, low drives
  logic                       e0_o_reg;          // Pin zero drive value
  logic                       e0_oe_n_reg;       // Pin zero enable, low drives
  logic                       e1_o_reg;          // Float pin drive value
  logic                       e1_oe_n_reg;       // Float pin enable, low drives

  // Decoded state and instruction
  wire sel_emu   = (ir_reg == `SEP_IR_EMUCTL);
  wire cap_dr    = (state_reg == SEP_CAP_DR);
  wire sh_dr     = (state_reg == SEP_SH_DR);
  wire upd_dr    = (state_reg == SEP_UPD_DR);
  wire cap_ir    = (state_reg == SEP_CAP_IR);
  wire sh_ir     = (state_reg == SEP_SH_IR);
  wire upd_ir    = (state_reg == SEP_UPD_IR);
  wire dr_serial = sel_emu ? emu_sr_reg[0] : bypass_reg;
  wire tdo_next  = sh_ir ? ir_sr_reg[0] : dr_serial;

  // Capture pattern: drive settings kept, pin levels and sampled select read back
  wire [`SEP_EMU_W-1:0] emu_capture = {ms2_reg,
                                       emulator_event_float_pin_i,
                                       emu_reg[`SEP_EMU_E1_DRV],
                                       emulator_event_pin_zero_i,
                                       emu_reg[`SEP_EMU_E0_DRV]};

  // Next state of the sixteen-state controller, steered by mode select
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SEP_TLR:    state_next = tms_i ? SEP_TLR    : SEP_RTI;
      SEP_RTI:    state_next = tms_i ? SEP_SEL_DR : SEP_RTI;
      SEP_SEL_DR: state_next = tms_i ? SEP_SEL_IR : SEP_CAP_DR;
      SEP_CAP_DR: state_next = tms_i ? SEP_EX1_DR : SEP_SH_DR;
      SEP_SH_DR:  state_next = tms_i ? SEP_EX1_DR : SEP_SH_DR;
      SEP_EX1_DR: state_next = tms_i ? SEP_UPD_DR : SEP_PA_DR;
      SEP_PA_DR:  state_next = tms_i ? SEP_EX2_DR : SEP_PA_DR;
      SEP_EX2_DR: state_next = tms_i ? SEP_UPD_DR : SEP_SH_DR;
      SEP_UPD_DR: state_next = tms_i ? SEP_SEL_DR : SEP_RTI;
      SEP_SEL_IR: state_next = tms_i ? SEP_TLR    : SEP_CAP_IR;
      SEP_CAP_IR: state_next = tms_i ? SEP_EX1_IR : SEP_SH_IR;
      SEP_SH_IR:  state_next = tms_i ? SEP_EX1_IR : SEP_SH_IR;
      SEP_EX1_IR: state_next = tms_i ? SEP_UPD_IR : SEP_PA_IR;
      SEP_PA_IR:  state_next = tms_i ? SEP_EX2_IR : SEP_PA_IR;
      SEP_EX2_IR: state_next = tms_i ? SEP_UPD_IR : SEP_SH_IR;
      SEP_UPD_IR: state_next = tms_i ? SEP_SEL_DR : SEP_RTI;
      default:    state_next = SEP_TLR;
    endcase
  end

  // Test reset low holds the whole scan side in reset, so the pins are ignored.
  // Hazard: release is not aligned to the test clock; the partner keeps mode
  // select high across release, which leaves the controller parked anyway.
  always_ff @(posedge tck_i or negedge trst_i) begin
    if (!trst_i) begin
      state_reg <= SEP_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Secondary mode select is sampled on every rising test clock edge
  always_ff @(posedge tck_i or negedge trst_i) begin
    if (!trst_i) begin
      ms2_reg <= 1'b1;
    end else begin
      ms2_reg <= secondary_mode_select_i;
    end
  end

  // Instruction path: capture, shift in test data, update
  always_ff @(posedge tck_i or negedge trst_i) begin
    if (!trst_i) begin
      ir_sr_reg <= `SEP_IR_CAPTURE;
    end else if (cap_ir) begin
      ir_sr_reg <= `SEP_IR_CAPTURE;
    end else if (sh_ir) begin
      ir_sr_reg <= {tdi_i, ir_sr_reg[`SEP_IR_W-1:1]};
    end
  end

  // Active instruction falls back to bypass in the reset state
  always_ff @(posedge tck_i or negedge trst_i) begin
    if (!trst_i) begin
      ir_reg <= `SEP_IR_BYPASS;
    end else if (state_reg == SEP_TLR) begin
      ir_reg <= `SEP_IR_BYPASS;
    end else if (upd_ir) begin
      ir_reg <= ir_sr_reg;
    end
  end

  // Bypass path captures zero and shifts test data
  always_ff @(posedge tck_i or negedge trst_i) begin
    if (!trst_i) begin
      bypass_reg <= 1'b0;
    end else if (cap_dr && !sel_emu) begin
      bypass_reg <= 1'b0;
    end else if (sh_dr && !sel_emu) begin
      bypass_reg <= tdi_i;
    end
  end

  // Emulation control shift stage
  always_ff @(posedge tck_i or negedge trst_i) begin
    if (!trst_i) begin
      emu_sr_reg <= `SEP_EMU_RESET;
    end else if (cap_dr && sel_emu) begin
      emu_sr_reg <= emu_capture;
    end else if (sh_dr && sel_emu) begin
      emu_sr_reg <= {tdi_i, emu_sr_reg[`SEP_EMU_W-1:1]};
    end
  end

  // Emulation control: pin directions and values set through scan
  always_ff @(posedge tck_i or negedge trst_i) begin
    if (!trst_i) begin
      emu_reg <= `SEP_EMU_RESET;
    end else if (state_reg == SEP_TLR) begin
      emu_reg <= `SEP_EMU_RESET;
    end else if (upd_dr && sel_emu) begin
      emu_reg <= emu_sr_reg;
    end
  end

  // Emulator pins driven only while test reset is high; reset releases them,
  // which leaves the float pin free to act as float control
  always_ff @(posedge tck_i or negedge trst_i) begin
    if (!trst_i) begin
      e0_o_reg    <= 1'b1;
      e0_oe_n_reg <= 1'b1;
      e1_o_reg    <= 1'b1;
      e1_oe_n_reg <= 1'b1;
    end else begin
      e0_o_reg    <= emu_reg[`SEP_EMU_E0_VAL];
      e0_oe_n_reg <= ~emu_reg[`SEP_EMU_E0_DRV];
      e1_o_reg    <= emu_reg[`SEP_EMU_E1_VAL];
      e1_oe_n_reg <= ~emu_reg[`SEP_EMU_E1_DRV];
    end
  end

  // Serial output changes on the falling edge, half a period before sampling
  always_ff @(negedge tck_i or negedge trst_i) begin
    if (!trst_i) begin
      tdo_reg      <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
    end else begin
      tdo_reg      <= tdo_next;
      tdo_oe_n_reg <= ~(sh_ir | sh_dr);
    end
  end

  assign tdo_o                           = tdo_reg;
  assign tdo_oe_n_o                      = tdo_oe_n_reg;
  assign emulator_event_pin_zero_o       = e0_o_reg;
  assign emulator_event_pin_zero_oe_n_o  = e0_oe_n_reg;
  assign emulator_event_float_pin_o      = e1_o_reg;
  assign emulator_event_float_pin_oe_n_o = e1_oe_n_reg;

  //----------------------------------------------------------------------------
  // System clock domain: scan hand-over and output float
  //----------------------------------------------------------------------------
  logic [`SEP_SYNC_W-1:0] sync1_reg;             // First stage, read by second only
  logic [`SEP_SYNC_W-1:0] sync2_reg;             // Second stage
  logic [`SEP_SYNC_W-1:0] sync3_reg;             // Third stage
  logic [`SEP_SYNC_W-1:0] pin_reg;               // Accepted pin levels
  logic                   scan_ctrl_reg;         // Device handed to scan
  logic                   float_reg;             // All output drivers released

  wire [`SEP_SYNC_W-1:0] pins_raw = {emulator_event_float_pin_i,
                                     emulator_event_pin_zero_i,
                                     trst_i};

  // A pin level counts once stages two and three agree, filtering one-cycle
  // glitches at the cost of one extra cycle of latency
  genvar g;
  generate
    for (g = 0; g < `SEP_SYNC_W; g = g + 1) begin : g_sync
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync1_reg[g] <= 1'b0;
          sync2_reg[g] <= 1'b0;
          sync3_reg[g] <= 1'b0;
          pin_reg[g]   <= 1'b0;
        end else begin
          sync1_reg[g] <= pins_raw[g];
          sync2_reg[g] <= sync1_reg[g];
          sync3_reg[g] <= sync2_reg[g];
          if (sync2_reg[g] == sync3_reg[g]) begin
            pin_reg[g] <= sync3_reg[g];
          end
        end
      end
    end
  endgenerate

  // Float needs test reset low, pin zero high and the float pin low
  wire float_cond = ~pin_reg[`SEP_SYNC_TRST] &
                    pin_reg[`SEP_SYNC_EMULATOR_EVENT_PIN_ZERO] &
                    ~pin_reg[`SEP_SYNC_EMU1];

  // Hand-over and float status for the rest of the device
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scan_ctrl_reg <= 1'b0;
      float_reg     <= 1'b0;
    end else begin
      scan_ctrl_reg <= pin_reg[`SEP_SYNC_TRST];
      float_reg     <= float_cond;
    end
  end

  assign scan_control_o  = scan_ctrl_reg;
  assign outputs_float_o = float_reg;

endmodule : sep_port

// *** test/sep_props.sv ***
// Concurrent checks of the scan emulation port at its pins
`timescale 1ns/1ps
module sep_props (
  // Clocks and resets
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic tck_i,
  input wire logic trst_i,
  // Scan and pin signals
  input wire logic tms_i,
  input wire logic tdo_oe_n_o,
  input wire logic emulator_event_pin_zero_i,
  input wire logic emulator_event_pin_zero_oe_n_o,
  input wire logic emulator_event_float_pin_i,
  input wire logic emulator_event_float_pin_oe_n_o,
  input wire logic scan_control_o,
  input wire logic outputs_float_o
);
  //----------------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------------
  // Float combination on the pins
  wire logic fl_req = !trst_i && emulator_event_pin_zero_i && !emulator_event_float_pin_i;
  // Both event pins released
  wire logic rel = emulator_event_pin_zero_oe_n_o && emulator_event_float_pin_oe_n_o;
  //----------------------------------------------------------------------------
  // Assertions; seven cycles leave room for the three-flop synchroniser
  //----------------------------------------------------------------------------
  float_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    fl_req [*7] |-> outputs_float_o) else $error("float not raised");
  float_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !fl_req [*7] |-> !outputs_float_o) else $error("float raised wrongly");
  scan_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    trst_i [*7] |-> scan_control_o) else $error("scan control missing");
  scan_clr_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !trst_i [*7] |-> !scan_control_o) else $error("scan control stuck");
  pin_rel_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !trst_i |-> rel) else $error("event pin driven in reset");
  tdo_idle_a: assert property (@(posedge tck_i) disable iff (!trst_i)
    tms_i [*5] |=> tdo_oe_n_o) else $error("tdo driven after reset path");
  pin_tlr_a: assert property (@(posedge tck_i) disable iff (!trst_i)
    tms_i [*6] |-> ##2 rel) else $error("event pins kept after reset path");
  shift_entry_a: assert property (@(posedge tck_i) disable iff (!trst_i)
    tms_i [*5] ##1 !tms_i ##1 tms_i ##1 !tms_i ##1 !tms_i |=> !tdo_oe_n_o)
    else $error("shift not entered");
  // Main scenarios reached
  cover property (@(posedge clk_i) outputs_float_o);
  cover property (@(posedge clk_i) scan_control_o);
  cover property (@(posedge tck_i) !tdo_oe_n_o);
endmodule : sep_props

bind sep_port sep_props i_props (.*);

// *** test/sep_emu_model.sv ***
// Behavioural emulator on the far side of the scan port
`timescale 1ns/1ps
module sep_emu_model (
  // Scan link toward the device
  output logic      tck_o,
  output logic      trst_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  // Pin requests: secondary select, float pin value/enable, pin zero value/enable
  output logic [4:0] drv_o
);
  // Pull-ups idle tms and tdi high; test clock stands low outside frames
  initial begin
    {tck_o, trst_o, tms_o, tdi_o} = 4'h7;
    drv_o = 5'h00;
    // Test reset starts high and falls a little later, so the scan side sees a
    // clean falling edge whatever order the time-zero processes start in
    #2 trst_o = 1'b0;
  end
  // Pin levels; the float combination is used only under test, never to share a bus
  task automatic drive(input logic [4:0] v);
    drv_o = v;
  endtask : drive
  // Test reset level
  task automatic set_trst(input logic v);
    trst_o = v;
  endtask : set_trst
  // One test clock period of 15 ns; tdo taken just before the rise
  task automatic bit_cyc(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #7.5;
    q = tdo_i;
    tck_o = 1'b1;
    #7.5;
    tck_o = 1'b0;
  endtask : bit_cyc
  // Reset path to Test-Logic-Reset, then Run-Test/Idle
  task automatic tap_reset;
    logic q;
    repeat (6) bit_cyc(1'b1, 1'b1, q);
    bit_cyc(1'b0, 1'b1, q);
  endtask : tap_reset
  // Scan n bits LSB first through IR or DR, from and back to Run-Test/Idle
  task automatic scan(input logic ir, input logic [4:0] din, input int n,
                      output logic [4:0] dout);
    logic q;
    dout = 5'h00;
    bit_cyc(1'b1, 1'b1, q);
    if (ir) bit_cyc(1'b1, 1'b1, q);
    bit_cyc(1'b0, 1'b1, q);
    bit_cyc(1'b0, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      bit_cyc(i == n - 1, din[i], q);
      dout[i] = q;
    end
    bit_cyc(1'b1, 1'b1, q);
    bit_cyc(1'b0, 1'b1, q);
    bit_cyc(1'b0, 1'b1, q);
    tms_o = 1'b1;
  endtask : scan
endmodule : sep_emu_model

// *** test/tb_top.sv ***
// Self-checking bench of the scan emulation port
`timescale 1ns/1ps
module tb_top;
  //----------------------------------------------------------------------------
  // Signals
  //----------------------------------------------------------------------------
  logic       clk_i;
  logic       rstn_i;
  int         errors;
  int         total_checks;
  logic [4:0] drv;
  wire logic  tck, trst, tms, tdi, tdo, tdo_oe_n, scan_ctl, out_float;
  wire logic  e0_o, e0_oe_n, e1_o, e1_oe_n;
  // Pin levels: device drive wins, then the emulator, else the pull-up
  wire logic  e0_w = (!e0_oe_n & e0_o) | (e0_oe_n & (!drv[0] | drv[1]));
  wire logic  e1_w = (!e1_oe_n & e1_o) | (e1_oe_n & (!drv[2] | drv[3]));
  // Test data output has a pull-down when released
  wire logic  tdo_w = !tdo_oe_n & tdo;
  always #4 clk_i = ~clk_i;
  sep_port i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .tck_i(tck), .trst_i(trst),
    .tms_i(tms), .secondary_mode_select_i(drv[4]), .tdi_i(tdi), .tdo_o(tdo),
    .tdo_oe_n_o(tdo_oe_n), .emulator_event_pin_zero_i(e0_w),
    .emulator_event_pin_zero_o(e0_o), .emulator_event_pin_zero_oe_n_o(e0_oe_n),
    .emulator_event_float_pin_i(e1_w), .emulator_event_float_pin_o(e1_o),
    .emulator_event_float_pin_oe_n_o(e1_oe_n), .scan_control_o(scan_ctl),
    .outputs_float_o(out_float));
  sep_emu_model i_emu (.tck_o(tck), .trst_o(trst), .tms_o(tms), .tdi_o(tdi),
    .tdo_i(tdo_w), .drv_o(drv));
  //----------------------------------------------------------------------------
  // Shared tasks
  //----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [4:0] seen, input logic [4:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // Bounded wait on scan control (sel=1) or float status (sel=0)
  task automatic wait_lvl(input string what, input logic sel, input logic v);
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      #1;
      if ((sel ? scan_ctl : out_float) === v) break;
    end
    chk(what, sel ? scan_ctl : out_float, v);
    if (k == 20) end_sim();
  endtask : wait_lvl
  //----------------------------------------------------------------------------
  // Scenarios
  //----------------------------------------------------------------------------
  // Float only for the full pin combination while scan is in reset
  task automatic t_float;
    i_emu.drive(5'h06);
    wait_lvl("float on", 1'b0, 1'b1);
    chk("scan off", scan_ctl, 1'b0);
    // Float pin still low but pin zero pulled low: the combination is broken
    i_emu.drive(5'h05);
    wait_lvl("float off", 1'b0, 1'b0);
    i_emu.drive(5'h00);
  endtask : t_float
  // Hand-over, instruction capture and bypass path
  task automatic t_bypass;
    logic [4:0] q;
    i_emu.set_trst(1'b1);
    wait_lvl("scan on", 1'b1, 1'b1);
    i_emu.tap_reset();
    chk("tdo idle", tdo_oe_n, 1'b1);
    i_emu.scan(1'b1, 5'h0F, 4, q);
    chk("ir capture", q[3:0], 4'h1);
    i_emu.scan(1'b0, 5'h16, 5, q);
    chk("bypass", q, 5'h0C);
  endtask : t_bypass
  // Event pin directions set through scan, capture of levels
  task automatic t_emu;
    logic [4:0] q;
    i_emu.scan(1'b1, 5'h02, 4, q);
    i_emu.scan(1'b0, 5'h01, 5, q);
    chk("pin0 oe", e0_oe_n, 1'b0);
    chk("pin0 out", e0_o, 1'b0);
    i_emu.drive(5'h14);
    i_emu.scan(1'b0, 5'h0C, 5, q);
    i_emu.drive(5'h10);
    chk("capture", q & 5'h1A, 5'h10);
    chk("float oe", e1_oe_n, 1'b0);
    chk("float out", e1_o, 1'b1);
    chk("pin0 rel", e0_oe_n, 1'b1);
    i_emu.tap_reset();
    chk("tlr rel", e1_oe_n, 1'b1);
    // Reset path falls back to the bypass path, entered straight from idle
    i_emu.scan(1'b0, 5'h16, 5, q);
    chk("tlr bypass", q, 5'h0C);
    i_emu.set_trst(1'b0);
    wait_lvl("scan back", 1'b1, 1'b0);
  endtask : t_emu
  //----------------------------------------------------------------------------
  // Main sequence
  //----------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    rstn_i = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (16) @(posedge clk_i);
    #1 rstn_i = 1'b1;
    t_float();
    t_bypass();
    t_emu();
    end_sim();
  end
endmodule : tb_top
